/* File: nvacc_array.sv */
// 512-byte store held in flip-flops, one byte per entry
// assumes the controller blocks reads while a write is being timed
`default_nettype none
module nvacc_array
   import nvacc_pkg::*;
(
   input wire logic i_clk,   // core clock
   nvacc_if.array bus        // address, data and program pulse
);
   logic [NV_DW-1:0] mem [NV_DEPTH];

   // storage has no reset: its content is meant to outlive a reset
   for (genvar g = 0; g < NV_DEPTH; g++) begin : g_byte
      always_ff @(posedge i_clk) begin
         if (bus.we && (bus.addr == NV_AW'(g))) begin
            mem[g] <= bus.wdata;
         end
      end
   end

   // combinational fetch, captured by the controller's data register
   assign bus.rdata = mem[bus.addr];
endmodule
`default_nettype wire

/* File: nvacc_cpu_model.sv */
// processor side model: issues one-cycle i/o register writes and reads
// assumes the caller waits out o_cpu_stall before the next access
`default_nettype none
module nvacc_cpu_model (
   input wire logic i_clk,          // core clock
   output logic [5:0] o_io_addr,    // register offset
   output logic o_io_wr,            // write strobe
   output logic o_io_rd,            // read strobe
   output logic [7:0] o_io_wdata,   // write data
   input wire logic [7:0] i_io_rdata // read data
);
   timeunit 1ns;
   timeprecision 100ps;
   // idle bus at time zero
   initial begin
      o_io_addr = 6'h00;
      o_io_wr = 1'b0;
      o_io_rd = 1'b0;
      o_io_wdata = 8'h00;
   end
   // one write, taken at the second edge; data inverted once released
   task automatic io_wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge i_clk);
      #1;
      o_io_addr = a;
      o_io_wdata = d;
      o_io_wr = 1'b1;
      @(posedge i_clk);
      #1;
      o_io_wr = 1'b0;
      o_io_wdata = ~d; // stale data must not look valid
   endtask
   // one read; registered data is settled just after the taking edge
   task automatic io_rd(input logic [5:0] a, output logic [7:0] d);
      @(posedge i_clk);
      #1;
      o_io_addr = a;
      o_io_rd = 1'b1;
      @(posedge i_clk);
      #1;
      o_io_rd = 1'b0;
      d = i_io_rdata;
   endtask
endmodule
`default_nettype wire

/* File: nvacc_ctrl.sv */
// nonvolatile byte access controller: i/o registers, armed write strobe,
// cpu stall and ready interrupt; instantiates the array and write timer
// assumes the cpu drives the i/o port on this clock and never issues an
// i/o access while o_cpu_stall is high
`default_nettype none

module nvacc_ctrl
   import nvacc_pkg::*;
#(
   parameter int WRITE_TICKS = WRITE_TICKS_DEF  // shorten for simulation
) (
   input wire logic i_clk,               // core clock, 125 MHz
   input wire logic i_rst_n,             // synchronous reset, active low
   input wire logic [5:0] i_io_addr,     // i/o register offset
   input wire logic i_io_wr,             // i/o write strobe, one cycle
   input wire logic i_io_rd,             // i/o read strobe, one cycle
   input wire logic [7:0] i_io_wdata,    // i/o write data
   output logic [7:0] o_io_rdata,        // i/o read data, registered
   input wire logic i_global_ie,         // cpu global interrupt enable
   output logic o_cpu_stall,             // holds the cpu while high
   output logic o_ready_irq              // ready interrupt level
);
   nvacc_if bus ();

   logic [NV_AW-1:0] nv_byte_address;
   logic [NV_DW-1:0] nv_data_reg;
   logic ready_irq_enable_reg;
   logic write_strobe_reg;
   logic read_strobe_reg;
   logic [2:0] arm_cnt_reg;
   logic write_arm;
   logic [2:0] stall_cnt_reg;
   logic irq_reg;
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;
   logic [7:0] nv_control_reg;
   logic [7:0] nv_address_high_reg;
   logic [7:0] nv_address_low_reg;
   logic wr_high;
   logic wr_low;
   logic wr_data;
   logic wr_ctrl;
   logic arm_set;
   logic wr_go;
   logic rd_go;

   // i/o write decode
   assign wr_high = i_io_wr && (i_io_addr == OFS_ADDR_HIGH);
   assign wr_low = i_io_wr && (i_io_addr == OFS_ADDR_LOW);
   assign wr_data = i_io_wr && (i_io_addr == OFS_DATA);
   assign wr_ctrl = i_io_wr && (i_io_addr == OFS_CTRL);

   // arming and strobes; a write needs the arm already standing
   assign arm_set = wr_ctrl && i_io_wdata[CTRL_WR_ARM];
   assign wr_go = wr_ctrl && i_io_wdata[CTRL_WR_STROBE] && write_arm
                  && !write_strobe_reg;
   // reads are refused while a write is open, and lose to a write start
   assign rd_go = wr_ctrl && i_io_wdata[CTRL_RD_STROBE] && !wr_go
                  && !write_strobe_reg;

   // address pair: frozen while a write is being timed
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         nv_byte_address <= ADDR_RST;
      end else if (!write_strobe_reg) begin
         if (wr_high) begin
            nv_byte_address[8] <= i_io_wdata[ADDR_HIGH_BIT];
         end
         if (wr_low) begin
            nv_byte_address[7:0] <= i_io_wdata;
         end
      end
   end

   // data register: cpu writes it, a read strobe refills it
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         nv_data_reg <= DATA_RST;
      end else if (rd_go) begin
         nv_data_reg <= bus.rdata;
      end else if (wr_data) begin
         nv_data_reg <= i_io_wdata;
      end
   end

   // interrupt enable bit
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         ready_irq_enable_reg <= 1'b0;
      end else if (wr_ctrl) begin
         ready_irq_enable_reg <= i_io_wdata[CTRL_IRQ_EN];
      end
   end

   // arm window: a countdown, so the bit drops by itself
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         arm_cnt_reg <= 3'h0;
      end else if (arm_set) begin
         arm_cnt_reg <= ARM_CYCLES;
      end else if (arm_cnt_reg != 3'h0) begin
         arm_cnt_reg <= arm_cnt_reg - 3'h1;
      end
   end
   assign write_arm = (arm_cnt_reg != 3'h0);

   // write strobe: set by an armed start, cleared by the timer
   // reset gives zero so software never waits on a write that is not there
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         write_strobe_reg <= 1'b0;
      end else if (wr_go) begin
         write_strobe_reg <= 1'b1;
      end else if (bus.done) begin
         write_strobe_reg <= 1'b0;
      end
   end

   // read strobe reads back high only for the cycle after the fetch
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         read_strobe_reg <= 1'b0;
      end else begin
         read_strobe_reg <= rd_go;
      end
   end

   // cpu stall counter
   // rd_go already loses to wr_go, so the two never load together
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         stall_cnt_reg <= 3'h0;
      end else if (rd_go) begin
         stall_cnt_reg <= RD_STALL_CYCLES;
      end else if (wr_go) begin
         stall_cnt_reg <= WR_STALL_CYCLES;
      end else if (stall_cnt_reg != 3'h0) begin
         stall_cnt_reg <= stall_cnt_reg - 3'h1;
      end
   end
   assign o_cpu_stall = (stall_cnt_reg != 3'h0);

   // ready interrupt is a level, not a flag: nothing to clear
   // the register adds one cycle of lag but keeps the level glitch free
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= ready_irq_enable_reg && i_global_ie && !write_strobe_reg;
      end
   end
   assign o_ready_irq = irq_reg;

   // readback images; unused bits are tied to zero
   assign nv_address_high_reg = {7'h00, nv_byte_address[8]};
   assign nv_address_low_reg = nv_byte_address[7:0];
   assign nv_control_reg = {4'h0, ready_irq_enable_reg, write_arm,
                            write_strobe_reg, read_strobe_reg};

   // read mux; unmapped offsets return zero
   always_comb begin
      case (i_io_addr)
         OFS_ADDR_HIGH: rdata_next = nv_address_high_reg;
         OFS_ADDR_LOW: rdata_next = nv_address_low_reg;
         OFS_DATA: rdata_next = nv_data_reg;
         OFS_CTRL: rdata_next = nv_control_reg;
         default: rdata_next = 8'h00;
      endcase
   end

   // read data is registered, one cycle after the read strobe
   // holding it until the next read lets the cpu sample it at leisure
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         rdata_reg <= RDATA_RST;
      end else if (i_io_rd) begin
         rdata_reg <= rdata_next;
      end
   end
   assign o_io_rdata = rdata_reg;

   // the byte is committed at the start; the timer only holds off reuse,
   // so later data register writes cannot corrupt the open write
   assign bus.addr = nv_byte_address;
   assign bus.wdata = nv_data_reg;
   assign bus.we = wr_go;
   assign bus.start = wr_go;

   // byte store
   nvacc_array u_array (
      .i_clk (i_clk),
      .bus (bus.array)
   );

   // write duration timer
   nvacc_timer #(
      .WRITE_TICKS (WRITE_TICKS)
   ) u_timer (
      .i_clk (i_clk),
      .i_rst_n (i_rst_n),
      .bus (bus.timer)
   );

   // checks on the control and timing behaviour
   // all checks rest while reset is low; the cpu may not access then
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_n);

   // stall lengths, and no stall without a start
   rd_stall_a: assert property (
      rd_go |=> o_cpu_stall[*4] ##1 !o_cpu_stall)
      else $error("read stall length wrong");

   wr_stall_a: assert property (
      wr_go |=> o_cpu_stall[*2] ##1 !o_cpu_stall)
      else $error("write stall length wrong");

   stall_cause_a: assert property (
      $rose(o_cpu_stall) |-> $past(rd_go) || $past(wr_go))
      else $error("stall without an access start");

   // arming window: open for four cycles, then shut by itself
   arm_window_a: assert property (
      arm_set |=> write_arm[*4])
      else $error("arm dropped too early");

   arm_timeout_a: assert property (
      arm_set ##1 (!arm_set)[*4] |=> !write_arm)
      else $error("arm did not clear after four cycles");

   // write strobe start and end
   unarmed_a: assert property (
      (wr_ctrl && !write_arm && !write_strobe_reg) |=> !write_strobe_reg)
      else $error("write started without arm");

   armed_start_a: assert property (
      (wr_ctrl && i_io_wdata[CTRL_WR_STROBE] && write_arm
       && !write_strobe_reg) |=> write_strobe_reg)
      else $error("armed strobe did not start write");

   strobe_clear_a: assert property (
      bus.done |=> !write_strobe_reg)
      else $error("write strobe not cleared at end");

   // read path: fetch lands in the data register, refused while busy
   read_data_a: assert property (
      rd_go |=> nv_data_reg == $past(bus.rdata))
      else $error("read data not loaded");

   read_refused_a: assert property (
      (wr_ctrl && i_io_wdata[CTRL_RD_STROBE] && write_strobe_reg)
      |=> $stable(nv_data_reg) && !o_cpu_stall)
      else $error("read taken during write");

   addr_frozen_a: assert property (
      write_strobe_reg |=> $stable(nv_byte_address))
      else $error("address changed during write");

   // ready interrupt level and its gates
   irq_block_a: assert property (
      write_strobe_reg |=> !o_ready_irq)
      else $error("ready interrupt while busy");

   irq_level_a: assert property (
      (ready_irq_enable_reg && i_global_ie && !write_strobe_reg) [*2]
      |-> o_ready_irq)
      else $error("ready interrupt missing");

   irq_gate_a: assert property (
      !i_global_ie |=> !o_ready_irq)
      else $error("ready interrupt without global enable");

   // reserved control bits read back as zero
   reserved_a: assert property (
      (i_io_rd && i_io_addr == OFS_CTRL) |=> o_io_rdata[7:4] == 4'h0)
      else $error("reserved control bits not zero");

   // main scenarios
   read_seen_c: cover property (rd_go);
   write_seen_c: cover property (bus.done ##1 !write_strobe_reg);
   arm_lapse_c: cover property (arm_set ##5 !write_strobe_reg && !write_arm);
   irq_seen_c: cover property ($rose(o_ready_irq));
   busy_read_c: cover property (
      wr_ctrl && i_io_wdata[CTRL_RD_STROBE] && write_strobe_reg);
endmodule
`default_nettype wire

/* File: nvacc_ctrl_tb.sv */
// self-checking bench for the nonvolatile byte access controller
// assumes a shortened write timer of 4 ticks of 125 core cycles each
`default_nettype none
module nvacc_ctrl_tb
   import nvacc_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int WT = 4;
   logic clk, rst_n, gie, stall, irq, io_wr, io_rd, ien;
   logic [5:0] io_addr;
   logic [7:0] wdata, rdata, v;
   int bad_count, cmp_count, cyc, t0;
   nvacc_ctrl #(.WRITE_TICKS(WT)) u_nvacc_ctrl (.i_clk(clk),
      .i_rst_n(rst_n), .i_io_addr(io_addr), .i_io_wr(io_wr),
      .i_io_rd(io_rd), .i_io_wdata(wdata), .o_io_rdata(rdata),
      .i_global_ie(gie), .o_cpu_stall(stall), .o_ready_irq(irq));
   nvacc_cpu_model u_nvacc_cpu_model (.i_clk(clk), .o_io_addr(io_addr),
      .o_io_wr(io_wr), .o_io_rd(io_rd), .o_io_wdata(wdata),
      .i_io_rdata(rdata));
   // clock and cycle count
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk) cyc <= cyc + 1;
   task automatic end_of_test();
      $display("counts: %0d compares, %0d mismatches", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic check(input string what, input logic [7:0] s, e);
      cmp_count++;
      if (s !== e) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", what, e, s);
      end
   endtask
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      u_nvacc_cpu_model.io_wr(a, d);
   endtask
   task automatic rd(input logic [5:0] a, output logic [7:0] d);
      u_nvacc_cpu_model.io_rd(a, d);
   endtask
   // counts stalled cycles after the taking edge, bounded
   task automatic stall_len(output logic [7:0] n);
      n = 8'h00;
      while (stall === 1'b1 && n < 8'h20) begin
         n++;
         @(posedge clk);
         #1;
      end
   endtask
   task automatic set_addr(input logic [8:0] a);
      wr(OFS_ADDR_HIGH, {7'h00, a[8]});
      wr(OFS_ADDR_LOW, a[7:0]);
   endtask
   // polls the write strobe; elapsed time checked against the tick count
   task automatic wait_ready();
      for (int i = 0; i < 1000; i++) begin
         rd(OFS_CTRL, v);
         if (v[1] === 1'b0) break;
      end
      check("write done", v & 8'h02, 8'h00);
      check("write time", 8'((cyc-t0) >= WT*125 && (cyc-t0) <= WT*125+132),
            8'h01);
   endtask
   task automatic nv_write(input logic [8:0] a, input logic [7:0] d,
                           input bit wt);
      logic [7:0] n;
      set_addr(a);
      wr(OFS_DATA, d);
      wr(OFS_CTRL, 8'h04 | {4'h0, ien, 3'h0});
      wr(OFS_CTRL, 8'h02 | {4'h0, ien, 3'h0});
      t0 = cyc;
      stall_len(n);
      check("write stall", n, 8'h02);
      rd(OFS_CTRL, v);
      check("strobe busy", v & 8'h02, 8'h02);
      if (wt) wait_ready();
   endtask
   task automatic nv_read(input logic [8:0] a, input logic [7:0] e);
      logic [7:0] n;
      set_addr(a);
      wr(OFS_CTRL, 8'h01 | {4'h0, ien, 3'h0});
      stall_len(n);
      check("read stall", n, 8'h04);
      rd(OFS_DATA, v);
      check("read byte", v, e);
   endtask
   task automatic t_reset();
      rd(OFS_CTRL, v);
      check("ctrl reset", v, 8'h00);
      rd(OFS_ADDR_HIGH, v);
      check("addr high reset", v, 8'h00);
      rd(OFS_DATA, v);
      check("data reset", v, DATA_RST);
      rd(6'h3F, v);
      check("unmapped", v, 8'h00);
      check("idle stall irq", {6'h00, stall, irq}, 8'h00);
      $display("test reset done");
   endtask
   task automatic t_fields();
      wr(OFS_ADDR_HIGH, 8'hFF);
      rd(OFS_ADDR_HIGH, v);
      check("addr high bits", v, 8'h01);
      wr(OFS_CTRL, 8'hF0);
      rd(OFS_CTRL, v);
      check("ctrl reserved", v, 8'h00);
      $display("test fields done");
   endtask
   task automatic t_store();
      nv_write(9'h000, 8'hA5, 1'b1);
      nv_write(9'h1FF, 8'h3C, 1'b1);
      nv_write(9'h100, 8'hC3, 1'b1);
      nv_read(9'h000, 8'hA5);
      nv_read(9'h1FF, 8'h3C);
      nv_read(9'h100, 8'hC3);
      $display("test store done");
   endtask
   // arming lapses; late or unarmed strobe must not program
   task automatic t_arm();
      logic [7:0] n;
      wr(OFS_CTRL, 8'h04);
      rd(OFS_CTRL, v);
      check("armed", v, 8'h04);
      repeat (4) @(posedge clk);
      rd(OFS_CTRL, v);
      check("arm lapsed", v, 8'h00);
      set_addr(9'h000);
      wr(OFS_DATA, 8'h5A);
      wr(OFS_CTRL, 8'h02);
      stall_len(n);
      check("unarmed stall", n, 8'h00);
      nv_read(9'h000, 8'hA5);
      $display("test arm done");
   endtask
   // reads and address changes refused while a write is open
   task automatic t_refuse();
      logic [7:0] n;
      nv_write(9'h011, 8'h77, 1'b0);
      wr(OFS_ADDR_LOW, 8'h22);
      wr(OFS_CTRL, 8'h01);
      stall_len(n);
      check("busy read stall", n, 8'h00);
      rd(OFS_ADDR_LOW, v);
      check("addr frozen", v, 8'h11);
      wait_ready();
      nv_read(9'h011, 8'h77);
      $display("test refuse done");
   endtask
   task automatic t_irq();
      ien = 1'b1;
      wr(OFS_CTRL, 8'h08);
      repeat (2) @(posedge clk);
      #1;
      check("irq on", {7'h00, irq}, 8'h01);
      gie = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      check("irq gated", {7'h00, irq}, 8'h00);
      gie = 1'b1;
      nv_write(9'h005, 8'h66, 1'b0);
      check("irq busy", {7'h00, irq}, 8'h00);
      wait_ready();
      repeat (2) @(posedge clk);
      #1;
      check("irq ready", {7'h00, irq}, 8'h01);
      ien = 1'b0;
      wr(OFS_CTRL, 8'h00);
      repeat (2) @(posedge clk);
      #1;
      check("irq off", {7'h00, irq}, 8'h00);
      $display("test irq done");
   endtask
   // main sequence
   initial begin
      rst_n = 1'b0;
      gie = 1'b1;
      ien = 1'b0;
      cyc = 0;
      t0 = 0;
      repeat (10) @(posedge clk);
      #1 rst_n = 1'b1;
      t_reset();
      t_fields();
      t_store();
      t_arm();
      t_refuse();
      t_irq();
      end_of_test();
   end
   // watchdog: the tests need well under 10000 cycles
   initial begin
      #(60000 * 8);
      bad_count++;
      $display("ERROR watchdog expected finish seen hang");
      end_of_test();
   end
endmodule
`default_nettype wire

/* File: nvacc_if.sv */
// carrier between the access controller, the byte array and the write timer
// assumes all three sit on the same core clock
`default_nettype none
interface nvacc_if;
   import nvacc_pkg::*;
   logic [NV_AW-1:0] addr;   // selected byte
   logic [NV_DW-1:0] wdata;  // byte to program
   logic we;                 // one-cycle program pulse
   logic [NV_DW-1:0] rdata;  // byte at addr
   logic start;              // one-cycle start of write timing
   logic done;               // one-cycle end of write timing
   modport ctrl (output addr, wdata, we, start, input rdata, done);
   modport array (input addr, wdata, we, output rdata);
   modport timer (input start, output done);
endinterface
`default_nettype wire

/* File: nvacc_pkg.sv */
// constants shared by the nonvolatile byte access block and its helpers
// assumes a single 125 MHz core clock and an 8-bit i/o register port
`default_nettype none
package nvacc_pkg;
   // array geometry
   localparam int NV_DEPTH = 512;
   localparam int NV_AW = 9;
   localparam int NV_DW = 8;
   // i/o register offsets within the block's 64-entry window
   localparam logic [5:0] OFS_ADDR_HIGH = 6'h10;
   localparam logic [5:0] OFS_ADDR_LOW = 6'h11;
   localparam logic [5:0] OFS_DATA = 6'h12;
   localparam logic [5:0] OFS_CTRL = 6'h13;
   // control register field positions
   localparam int CTRL_RD_STROBE = 0;
   localparam int CTRL_WR_STROBE = 1;
   localparam int CTRL_WR_ARM = 2;
   localparam int CTRL_IRQ_EN = 3;
   // address high register field position
   localparam int ADDR_HIGH_BIT = 0;
   // reset values
   localparam logic [NV_AW-1:0] ADDR_RST = 9'h000;
   localparam logic [NV_DW-1:0] DATA_RST = 8'h00;
   localparam logic [NV_DW-1:0] RDATA_RST = 8'h00;
   // cycle counts on the core clock
   localparam logic [2:0] RD_STALL_CYCLES = 3'h4;
   localparam logic [2:0] WR_STALL_CYCLES = 3'h2;
   localparam logic [2:0] ARM_CYCLES = 3'h4;
   // write timing: calibrated oscillator ticks derived from the core clock
   localparam int CLK_FREQ_HZ = 125000000;
   localparam int RC_FREQ_HZ = 1000000;
   localparam int RC_DIV_CYCLES = CLK_FREQ_HZ / RC_FREQ_HZ;
   localparam int WRITE_TICKS_DEF = 8448;
endpackage
`default_nettype wire

/* File: nvacc_timer.sv */
// write duration timer driven by a divided oscillator tick
// assumes start is never pulsed while a write is already being timed
`default_nettype none
module nvacc_timer
   import nvacc_pkg::*;
#(
   parameter int WRITE_TICKS = WRITE_TICKS_DEF  // oscillator ticks per write
) (
   input wire logic i_clk,    // core clock
   input wire logic i_rst_n,  // synchronous reset, active low
   nvacc_if.timer bus         // start and done pulses
);
   logic [6:0] div_reg;
   logic tick;
   logic busy_reg;
   logic [13:0] ticks_reg;

   // free-running divider stands in for the calibrated oscillator
   always_ff @(posedge i_clk) begin
      if (!i_rst_n || tick) begin
         div_reg <= 7'h00;
      end else begin
         div_reg <= div_reg + 7'h01;
      end
   end
   assign tick = (div_reg == 7'(RC_DIV_CYCLES - 1));

   // count oscillator ticks while a write is open
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         busy_reg <= 1'b0;
         ticks_reg <= 14'h0000;
      end else if (bus.start) begin
         busy_reg <= 1'b1;
         ticks_reg <= 14'h0000;
      end else if (bus.done) begin
         busy_reg <= 1'b0;
      end else if (busy_reg && tick) begin
         ticks_reg <= ticks_reg + 14'h0001;
      end
   end

   // done fires once the full tick count has passed
   // the first tick after start only closes a part period of the
   // oscillator, so one more is counted to never cut a write short
   assign bus.done = busy_reg && (ticks_reg == 14'(WRITE_TICKS + 1));
endmodule
`default_nettype wire
